// ### rtl/isr_pin_sync.sv
// three-flop synchroniser for asynchronous pin inputs
// a change counts only once the second and third stages agree
`timescale 1ns/100ps
module isr_pin_sync (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic clk32_pin, // raw 32 kHz clock
  input wire logic vsync_pin, // raw video port vsync
  isr_sync_if.source sync // filtered levels
);
  logic [2:0] s32;
  logic [2:0] svs;
  logic [2:0] next_s32;
  logic [2:0] next_svs;
  logic l32;
  logic lvs;
  logic next_l32;
  logic next_lvs;

  always_comb begin
    next_s32 = {s32[1:0], clk32_pin};
    next_svs = {svs[1:0], vsync_pin};
    next_l32 = (s32[1] == s32[2]) ? s32[2] : l32;
    next_lvs = (svs[1] == svs[2]) ? svs[2] : lvs;
  end

  // vsync level resets high so no false falling edge appears after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s32 <= 3'h0;
      svs <= 3'h7;
      l32 <= 1'b0;
      lvs <= 1'b1;
    end else begin
      s32 <= next_s32;
      svs <= next_svs;
      l32 <= next_l32;
      lvs <= next_lvs;
    end
  end

  assign sync.clk32_level = l32;
  assign sync.vsync_level = lvs;
endmodule

// ### rtl/isr_pkg.sv
// package for the id and status register group
// assumes an 8-bit indexed register port shared with the rest of the controller
package isr_pkg;
  localparam logic [7:0] IDX_REVISION_LOW = 8'h25;
  localparam logic [7:0] IDX_DEVICE_IDENTIFIER = 8'h27;
  localparam logic [7:0] IDX_POWER_VIDEO_STATUS = 8'h29;
  localparam int REV_WIDTH = 10;
  localparam int DEV_ID_WIDTH = 6;
  // device id field sits in [7:2], revision high bits in [1:0]
  localparam int DEV_ID_LSB = 2;
  localparam int REV_HI_LSB = 0;
  localparam int ST_SUSPEND_BIT = 7;
  localparam int ST_CLK32_BIT = 6;
  localparam int ST_PWRSEQ_BIT = 5;
  localparam int ST_STANDBY_BIT = 4;
  localparam int ST_FIELD_BIT = 3;
  localparam int ST_EXPAND_BIT = 2;
  localparam logic FIELD_RESET = 1'b1;
  localparam logic [7:0] STATUS_RESET = 8'h08;
  // arbitrary neutral identity values
  localparam logic [9:0] REVISION_DEFAULT = 10'h001;
  localparam logic [5:0] DEVICE_ID_DEFAULT = 6'h15;
  // 32 ms hold after clocks restart, at 40 MHz
  localparam int CLOCK_HZ = 40000000;
  localparam int RESTART_HOLD_MS = 32;
  localparam int RESTART_HOLD_CYCLES = CLOCK_HZ / 1000 * RESTART_HOLD_MS;
  localparam int HOLD_CNT_WIDTH = 21;
endpackage

// ### rtl/isr_regs.sv
// id and status register group, read through the indexed register port
// assumes suspend, standby, power sequencing and expansion state come from
// the power manager and scaler as same-clock levels
`timescale 1ns/100ps
// Notes on behaviour
// - revision is 10 bits; low 8 bits read at revision_low
// - revision bits 9:8 read in device_identifier bits 1:0
// - fixed 6-bit device id in device_identifier bits 7:2, writes ignored
// - status bit 7 set in suspend, held until 32 ms after clocks restart
// - suspend_state_n pin low whenever suspend status bit is set
// - status bit 6 follows the live 32 kHz clock level
// - status bit 5 set throughout any lcd power-up or power-down sequence
// - hardware suspend refuses all register access; power sequence bit readable otherwise
// - status bit 4 set in standby, held until 32 ms after clocks restart
// - standby_state_n pin low whenever standby status bit is set
// - status bit 3 toggles on each vsync falling edge, resets to one
// - status bit 2 set when expansion enabled on 800x600 or 1024x768 panel
module isr_regs
  import isr_pkg::*;
(
  input wire logic clock, // 40 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] reg_index, // indexed port register index
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic reg_wr, // write strobe, ignored here
  input wire logic [7:0] reg_wdata, // write data, ignored here
  output logic [7:0] reg_rdata, // read data, held until next answered read
  output logic reg_rvalid, // read data valid, one-cycle pulse
  input wire logic suspend_active, // device in suspend
  input wire logic standby_active, // device in standby
  input wire logic clocks_stopped, // clocks stopped by power manager
  input wire logic hw_suspend, // hardware-controlled suspend
  input wire logic power_seq_busy, // lcd power sequence running
  input wire logic expand_enabled, // panel expansion enabled
  input wire logic panel_large, // panel is 800x600 or 1024x768
  input wire logic clk32_pin, // 32 kHz clock pin
  input wire logic vsync_pin, // video port vertical sync pin
  output logic suspend_state_n, // low while in suspend
  output logic standby_state_n // low while in standby
);
  import isr_pkg::*;

  isr_sync_if sync_bus ();

  isr_pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .clk32_pin(clk32_pin),
    .vsync_pin(vsync_pin),
    .sync(sync_bus)
  );

  logic susp_st, next_susp_st;
  logic sby_st, next_sby_st;
  logic [HOLD_CNT_WIDTH-1:0] susp_cnt, next_susp_cnt;
  logic [HOLD_CNT_WIDTH-1:0] sby_cnt, next_sby_cnt;
  logic field, next_field;
  logic vs_prev, next_vs_prev;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [7:0] status;

  localparam logic [HOLD_CNT_WIDTH-1:0] HOLD = HOLD_CNT_WIDTH'(RESTART_HOLD_CYCLES);
  localparam logic [9:0] REVISION = REVISION_DEFAULT;

  // hold counter restarts each time clocks stop, then runs out after restart
  function automatic logic [HOLD_CNT_WIDTH-1:0] hold_next(
    input logic mode, input logic stopped, input logic [HOLD_CNT_WIDTH-1:0] cnt);
    if (mode || stopped)
      hold_next = HOLD;
    else if (cnt != '0)
      hold_next = cnt - 1'b1;
    else
      hold_next = cnt;
  endfunction

  always_comb begin
    next_susp_cnt = hold_next(suspend_active, clocks_stopped && susp_st, susp_cnt);
    next_sby_cnt = hold_next(standby_active, clocks_stopped && sby_st, sby_cnt);
    // stays set from entry until the 32 ms hold after restart has elapsed
    next_susp_st = suspend_active || (susp_st && next_susp_cnt != '0);
    next_sby_st = standby_active || (sby_st && next_sby_cnt != '0);
    next_vs_prev = sync_bus.vsync_level;
    next_field = (vs_prev && !sync_bus.vsync_level) ? !field : field;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      susp_st <= 1'b0;
      sby_st <= 1'b0;
      susp_cnt <= '0;
      sby_cnt <= '0;
      field <= FIELD_RESET;
      vs_prev <= 1'b1;
      suspend_state_n <= 1'b1;
      standby_state_n <= 1'b1;
    end else begin
      susp_st <= next_susp_st;
      sby_st <= next_sby_st;
      susp_cnt <= next_susp_cnt;
      sby_cnt <= next_sby_cnt;
      field <= next_field;
      vs_prev <= next_vs_prev;
      suspend_state_n <= !next_susp_st;
      standby_state_n <= !next_sby_st;
    end
  end

  always_comb begin
    status = 8'h00;
    status[ST_SUSPEND_BIT] = susp_st;
    status[ST_CLK32_BIT] = sync_bus.clk32_level;
    status[ST_PWRSEQ_BIT] = power_seq_busy;
    status[ST_STANDBY_BIT] = sby_st;
    status[ST_FIELD_BIT] = field;
    status[ST_EXPAND_BIT] = expand_enabled && panel_large;
  end

  // reg_wr and reg_wdata are deliberately unused: the whole group is read-only
  always_comb begin
    next_rdata = reg_rdata;
    next_rvalid = 1'b0;
    if (reg_rd && !hw_suspend) begin
      next_rvalid = 1'b1;
      unique case (reg_index)
        IDX_REVISION_LOW: next_rdata = REVISION[7:0];
        IDX_DEVICE_IDENTIFIER:
          next_rdata = {DEVICE_ID_DEFAULT, REVISION[REV_WIDTH-1:8]};
        IDX_POWER_VIDEO_STATUS: next_rdata = status;
        default: next_rvalid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end
endmodule

// ### rtl/isr_sync_if.sv
// interface carrying synchronised pin levels from the synchroniser to the top
// assumes a single clock domain
`timescale 1ns/100ps
interface isr_sync_if;
  logic clk32_level; // synchronised 32 kHz clock level
  logic vsync_level; // synchronised vertical sync level
  modport source (output clk32_level, output vsync_level);
  modport sink (input clk32_level, input vsync_level);
endinterface

// ### sim/isr_host.sv
// host model issuing indexed register reads
// assumes a one-cycle answer marked by reg_rvalid
`timescale 1ns/100ps
module isr_host (
  input wire logic clock, // system clock
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // answer
  output logic [7:0] reg_index, // index
  output logic reg_rd // read strobe
);
  initial begin
    reg_rd = 1'b0;
    reg_index = 8'h00;
  end
  // nothing read steers the host itself; index is moved after the take so stale hides nothing
  task automatic read(input logic [7:0] idx, output logic v, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_index <= idx;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_index <= ~idx;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// ### sim/isr_regs_bench.sv
// bench for the id and status register group
// drives state levels and pins, reads through the host model
`timescale 1ns/100ps
module isr_regs_bench;
  import isr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_index, reg_rdata, d;
  logic reg_rd, reg_rvalid, v, sus_n, sby_n;
  logic sus = 0, sby = 0, hws = 0, pws = 0, exe = 0, pnl = 0, c32 = 0, vs = 1, fld = FIELD_RESET;
  logic stp = 0;
  int miscompares = 0;
  int n_compared = 0;
  always #12.5 clock = ~clock;
  isr_regs u_isr_regs (.clock(clock), .rst(rst), .reg_index(reg_index), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .suspend_active(sus), .standby_active(sby), .clocks_stopped(stp), .hw_suspend(hws),
    .power_seq_busy(pws), .expand_enabled(exe), .panel_large(pnl), .clk32_pin(c32),
    .vsync_pin(vs), .suspend_state_n(sus_n), .standby_state_n(sby_n));
  isr_host u_isr_host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_index(reg_index), .reg_rd(reg_rd));
  function automatic logic [7:0] st(logic c, p, f, e, l);
    return {1'b0, c, p, 1'b0, f, e & l, 2'b00};
  endfunction
  task chk8(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0t data %h not %h", $time, g, e);
    end
  endtask
  task chkb(input logic g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0t flag %b not %b", $time, g, e);
    end
  endtask
  task complete_run;
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial begin
    void'($urandom(50865));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    u_isr_host.read(IDX_POWER_VIDEO_STATUS, v, d);
    chk8(d, STATUS_RESET);
    reg_wr <= 1'b1;
    reg_wdata <= 8'hFF;
    u_isr_host.read(IDX_REVISION_LOW, v, d);
    chk8(d, REVISION_DEFAULT[7:0]);
    u_isr_host.read(IDX_DEVICE_IDENTIFIER, v, d);
    chk8(d, {DEVICE_ID_DEFAULT, REVISION_DEFAULT[9:8]});
    reg_wr <= 1'b0;
    u_isr_host.read(8'h26, v, d);
    chkb(v, 1'b0);
    @(posedge clock) hws <= 1'b1;
    u_isr_host.read(IDX_POWER_VIDEO_STATUS, v, d);
    chkb(v, 1'b0);
    @(posedge clock) hws <= 1'b0;
    repeat (24) begin
      @(posedge clock) {pws, exe, pnl, c32} <= 4'($urandom);
      if ($urandom % 2) begin
        vs <= 1'b0;
        fld = ~fld;
      end
      repeat (8) @(posedge clock);
      vs <= 1'b1;
      u_isr_host.read(IDX_POWER_VIDEO_STATUS, v, d);
      chk8(d, st(c32, pws, fld, exe, pnl));
    end
    @(posedge clock) {sus, sby, stp} <= 3'b111;
    repeat (2) @(posedge clock);
    #1 chkb(sus_n, 1'b0);
    chkb(sby_n, 1'b0);
    // modes drop while clocks are still stopped: bits must stay set
    @(posedge clock) {sus, sby} <= 2'b00;
    repeat (10) @(posedge clock);
    u_isr_host.read(IDX_POWER_VIDEO_STATUS, v, d);
    chk8(d & 8'h90, 8'h90);
    @(posedge clock) stp <= 1'b0;
    repeat (10) @(posedge clock);
    u_isr_host.read(IDX_POWER_VIDEO_STATUS, v, d);
    chk8(d & 8'h90, 8'h90);
    #1 chkb(sus_n, 1'b0);
    chkb(sby_n, 1'b0);
    complete_run();
  end
endmodule

// ### sim/isr_regs_properties.sv
// assertions on the id and status register group
// bound to isr_regs, sees only its ports
`timescale 1ns/100ps
module isr_regs_properties
  import isr_pkg::*;
(
  input wire logic clock, // clock
  input wire logic rst, // reset
  input wire logic [7:0] reg_index, // index
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // answer
  input wire logic hw_suspend, // lockout
  input wire logic suspend_active, // suspend
  input wire logic standby_active, // standby
  input wire logic power_seq_busy, // sequencing
  input wire logic suspend_state_n, // pin
  input wire logic standby_state_n // pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence take(logic [7:0] idx);
    reg_rd && !hw_suspend && reg_index == idx;
  endsequence
  logic mapped;
  assign mapped = reg_index inside {IDX_REVISION_LOW, IDX_DEVICE_IDENTIFIER, IDX_POWER_VIDEO_STATUS};
  a_read_answered: assert property (reg_rd && !hw_suspend && mapped |=> reg_rvalid)
    else $error("read not answered");
  a_read_refused: assert property (!(reg_rd && !hw_suspend && mapped) |=> !reg_rvalid)
    else $error("read answered when refused");
  a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  a_rev_low: assert property (take(IDX_REVISION_LOW) |=> reg_rdata == REVISION_DEFAULT[7:0])
    else $error("revision low wrong");
  a_dev_id: assert property (take(IDX_DEVICE_IDENTIFIER) |=>
    reg_rdata == {DEVICE_ID_DEFAULT, REVISION_DEFAULT[9:8]}) else $error("id wrong");
  a_reserved_zero: assert property (take(IDX_POWER_VIDEO_STATUS) |=> reg_rdata[1:0] == 2'b00)
    else $error("reserved bits set");
  a_pwrseq_bit: assert property (power_seq_busy[*3] ##0 take(IDX_POWER_VIDEO_STATUS)
    |=> reg_rdata[5]) else $error("sequence bit clear");
  a_suspend_pin: assert property (suspend_active |=> !suspend_state_n)
    else $error("suspend pin high");
  a_standby_pin: assert property (standby_active |=> !standby_state_n)
    else $error("standby pin high");
endmodule
bind isr_regs isr_regs_properties u_isr_regs_properties (.*);
